// *** test/ipe_host_model.sv ***
// Host processor model that issues acknowledge pulse sequences.
`timescale 1ns/1ps
module ipe_host_model (
  input  wire logic       i_clk,
  input  wire logic       i_rstn,
  input  wire logic       i_go,
  input  wire logic [1:0] i_count,
  output logic            o_ack_pulse,
  output logic            o_busy
);
  logic [1:0] left_r;
  logic [2:0] phase_r;
  // ==========================================================
  // Pulse generator
  // Each pulse is three cycles high and three low, so the synchroniser never drops one.
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      o_busy      <= 1'b0;
      o_ack_pulse <= 1'b0;
      left_r      <= 2'h0;
      phase_r     <= 3'h0;
    end else if (!o_busy && i_go) begin
      o_busy      <= 1'b1;
      o_ack_pulse <= 1'b1;
      left_r      <= i_count;
      phase_r     <= 3'h0;
    end else if (o_busy) begin
      phase_r <= phase_r + 3'h1;
      if (phase_r == 3'h2) begin
        o_ack_pulse <= 1'b0;
      end
      if (phase_r == 3'h5) begin
        phase_r <= 3'h0;
        if (left_r == 2'h1) begin
          o_busy <= 1'b0;
        end else begin
          left_r      <= left_r - 2'h1;
          o_ack_pulse <= 1'b1;
        end
      end
    end
  end
endmodule

// *** test/tb_top.sv ***
// Self-checking bench for the priority and end-of-service block.
`timescale 1ns/1ps
`include "ipe_map.svh"
module tb_top;
  logic        clk, rstn, psel, penable, pwrite, int_o, irq_o, pready, pslverr, ack, busy, go, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [7:0]  req;
  logic [1:0]  cnt;
  int          bad_count = 0;
  int          total_checks = 0;
  ipe_core dut (.I_CLK(clk), .I_RSTN(rstn), .I_REQUEST_LINE(req), .I_ACKNOWLEDGE_PULSE(ack),
    .I_PSEL(psel), .I_PENABLE(penable), .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata),
    .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr), .O_INT(int_o), .O_IRQ(irq_o));
  ipe_host_model host (.i_clk(clk), .i_rstn(rstn), .i_go(go), .i_count(cnt), .o_ack_pulse(ack),
    .o_busy(busy));
  // ==========================================================
  // Clock and helpers
  // Free-running clock at 100 MHz.
  always #5 clk = ~clk;
  task automatic test_done;
    if (bad_count == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // One APB transfer; the request is held until pready is sampled high.
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    @(posedge clk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd      = prdata;
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask
  task automatic wait_n(input int n);
    repeat (n) @(posedge clk);
  endtask
  // Runs a sequence of n acknowledge pulses, which may be fewer than a full sequence, and lets the synchroniser settle afterwards.
  task automatic ack_seq(input logic [1:0] n);
    @(posedge clk);
    go  <= 1'b1;
    cnt <= n;
    @(posedge clk);
    go  <= 1'b0;
    do @(posedge clk); while (busy === 1'b1);
    wait_n(6);
  endtask
  // ==========================================================
  // Watchdog
  // The whole sequence needs well under 3000 cycles.
  initial begin
    wait_n(20000);
    bad_count++;
    test_done;
  end
  // ==========================================================
  // Main sequence
  initial begin
    clk = 0; rstn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
    req = 0; go = 0; cnt = 0;
    wait_n(12);
    rstn <= 1'b1;
    rd_chk(`IPE_OFF_INSVC, 32'h0);
    rd_chk(`IPE_OFF_LOWEST, 32'h7);
    rd_chk(12'h01c, 32'h0);
    chk(err, 1'b1);
    req <= 8'h08;
    wait_n(6);
    chk(int_o, 1'b1);
    ack_seq(2'h3);
    rd_chk(`IPE_OFF_INSVC, 32'h08);
    chk(int_o, 1'b0);
    req <= 8'h0a;
    wait_n(6);
    chk(int_o, 1'b1);
    ack_seq(2'h3);
    rd_chk(`IPE_OFF_INSVC, 32'h0a);
    wait_n(20);
    rd_chk(`IPE_OFF_INSVC, 32'h0a);
    chk(int_o, 1'b0);
    // Explicit commands stand in for an automatic clear, as a cascade slave would need.
    apb(1'b1, `IPE_OFF_CMD, 32'h33);
    rd_chk(`IPE_OFF_INSVC, 32'h02);
    apb(1'b1, `IPE_OFF_CMD, 32'h10);
    rd_chk(`IPE_OFF_INSVC, 32'h0);
    ack_seq(2'h3);
    rd_chk(`IPE_OFF_INSVC, 32'h02);
    apb(1'b1, `IPE_OFF_CMD, 32'h50);
    rd_chk(`IPE_OFF_INSVC, 32'h0);
    rd_chk(`IPE_OFF_LOWEST, 32'h1);
    ack_seq(2'h3);
    rd_chk(`IPE_OFF_INSVC, 32'h08);
    apb(1'b1, `IPE_OFF_CMD, 32'h33);
    rd_chk(`IPE_OFF_INSVC, 32'h0);
    apb(1'b1, `IPE_OFF_CTRL, 32'h5);
    apb(1'b1, `IPE_OFF_STAT, 32'h3);
    apb(1'b1, `IPE_OFF_IMASK, 32'h3);
    ack_seq(2'h2);
    rd_chk(`IPE_OFF_INSVC, 32'h0);
    chk(int_o, 1'b1);
    rd_chk(`IPE_OFF_STAT, 32'h3);
    chk(irq_o, 1'b1);
    apb(1'b1, `IPE_OFF_IMASK, 32'h0);
    wait_n(3);
    chk(irq_o, 1'b0);
    apb(1'b1, `IPE_OFF_IMASK, 32'h3);
    apb(1'b1, `IPE_OFF_STAT, 32'h3);
    wait_n(3);
    chk(irq_o, 1'b0);
    rd_chk(`IPE_OFF_STAT, 32'h0);
    apb(1'b1, `IPE_OFF_CTRL, 32'h7);
    ack_seq(2'h2);
    rd_chk(`IPE_OFF_LOWEST, 32'h3);
    rd_chk(`IPE_OFF_INSVC, 32'h0);
    // Call-opcode mode: the automatic clear waits for the third trailing edge.
    apb(1'b1, `IPE_OFF_CTRL, 32'h1);
    ack_seq(2'h2);
    rd_chk(`IPE_OFF_INSVC, 32'h02);
    ack_seq(2'h1);
    rd_chk(`IPE_OFF_INSVC, 32'h0);
    rd_chk(`IPE_OFF_LOWEST, 32'h3);
    apb(1'b1, `IPE_OFF_CTRL, 32'h0);
    ack_seq(2'h3);
    rd_chk(`IPE_OFF_INSVC, 32'h02);
    apb(1'b1, `IPE_OFF_CMD, 32'h31);
    rd_chk(`IPE_OFF_INSVC, 32'h0);
    test_done;
  end
endmodule

// *** verilog/ipe_core.sv ***
// Interrupt in-service tracking, priority resolution and end-of-service logic with an APB register port.
// Operation
// R1 - Acknowledge sets in-service bit of chosen level
// R2 - In-service bit holds until end-of-service
// R3 - Only strictly higher requests raise interrupt
// R4 - Reset gives nested order, level zero highest
// R5 - Acknowledge picks highest-priority pending request
// R6 - Nesting relaxed in automatic end-of-service mode
// R7 - Non-specific command clears highest in-service bit
// R8 - Host uses non-specific only when nesting holds
// R9 - Specific command clears exactly the named bit
// R10 - Specific command works in every mode
// R11 - Automatic mode clears at final acknowledge trailing edge
// R12 - Automatic mode lets later requests interrupt
// R13 - Cascade slaves need explicit end-of-service commands
// R14 - Host masks its input with automatic mode
// R15 - Rotating command makes cleared level lowest
// R16 - Automatic rotation makes serviced level lowest
// R17 - Three-bit lowest pointer resets to seven
// R18 - Command encoding defined by this design
//
// Local design decisions: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
`include "ipe_map.svh"
module ipe_core (
  input  wire logic        I_CLK,
  input  wire logic        I_RSTN,
  input  wire logic [7:0]  I_REQUEST_LINE,
  input  wire logic        I_ACKNOWLEDGE_PULSE,
  input  wire logic        I_PSEL,
  input  wire logic        I_PENABLE,
  input  wire logic        I_PWRITE,
  input  wire logic [11:0] I_PADDR,
  input  wire logic [31:0] I_PWDATA,
  output logic      [31:0] O_PRDATA,
  output logic             O_PREADY,
  output logic             O_PSLVERR,
  output logic             O_INT,
  output logic             O_IRQ
);

  // =====================================================================
  // Pin synchronisers
  logic [7:0] req_s1_r;
  logic [7:0] req_s2_r;
  logic       ack_s1_r;
  logic       ack_s2_r;
  logic       ack_d_r;

  // Request lines and acknowledge come from outside; two stages each.
  always_ff @(posedge I_CLK) begin
    if (!I_RSTN) begin
      req_s1_r <= 8'h00;
      req_s2_r <= 8'h00;
      ack_s1_r <= 1'b0;
      ack_s2_r <= 1'b0;
      ack_d_r  <= 1'b0;
    end else begin
      req_s1_r <= I_REQUEST_LINE;
      req_s2_r <= req_s1_r;
      ack_s1_r <= I_ACKNOWLEDGE_PULSE;
      ack_s2_r <= ack_s1_r;
      ack_d_r  <= ack_s2_r;
    end
  end

  logic ack_rise;
  logic ack_fall;
  // Edges are taken from the second stage, never the first, which may still be settling.
  assign ack_rise = ack_s2_r & ~ack_d_r;
  assign ack_fall = ~ack_s2_r & ack_d_r;

  // =====================================================================
  // State
  logic [7:0]        in_service_bits_r;
  logic [7:0]        pending_request_bits;
  logic [2:0]        lowest_r;
  logic [2:0]        ctrl_r;
  logic [7:0]        irq_mask_r;
  logic [1:0]        irq_stat_r;
  logic [2:0]        sel_level_r;
  ipe_pkg::ipe_ack_type ack_state_r;

  // Pending requests are the synchronised levels; triggering is outside this block.
  assign pending_request_bits = req_s2_r;

  // Rotate a vector so the current highest-priority level sits at bit 0.
  // Doubling the vector turns a plain shift into a rotate.
  function automatic logic [7:0] rot_dn(input logic [7:0] v, input logic [2:0] low);
    logic [15:0] d;
    d = {v, v} >> (4'(low) + 4'h1);
    return d[7:0];
  endfunction

  // Index (in rotated order) of the first set bit, and whether any is set.
  // The scan runs downward so the lowest index, the highest priority, is written last.
  function automatic logic [3:0] first_set(input logic [7:0] v);
    logic [3:0] r;
    r = 4'h8;
    for (int i = 7; i >= 0; i--) begin
      if (v[i]) begin
        r = 4'(i);
      end
    end
    return r;
  endfunction

  logic [3:0] req_pos;
  logic [3:0] isr_pos;
  logic [2:0] req_level;
  logic [2:0] isr_level;
  logic       int_nxt;

  // Priority is resolved relative to the rotating pointer. [R17]
  always_comb begin
    req_pos   = first_set(rot_dn(pending_request_bits, lowest_r));
    isr_pos   = first_set(rot_dn(in_service_bits_r, lowest_r));
    req_level = 3'(lowest_r + 3'h1 + req_pos[2:0]);
    isr_level = 3'(lowest_r + 3'h1 + isr_pos[2:0]);
    // A request interrupts only if strictly above every in-service level. [R3] [R6] [R12]
    int_nxt   = !req_pos[3] && (req_pos < isr_pos);
  end

  // =====================================================================
  // APB decode
  logic       wr_en;
  logic       rd_en;
  logic       cmd_wr;
  logic [2:0] cmd_op;
  logic [2:0] cmd_lvl;
  logic       mapped;

  // Reads are decoded in setup so the data is registered by the access edge.
  // Writes land only at the access edge, the one at which pready is sampled high.
  assign wr_en   = I_PSEL & I_PENABLE & I_PWRITE;
  assign rd_en   = I_PSEL & ~I_PENABLE & ~I_PWRITE;
  assign cmd_wr  = wr_en && (I_PADDR == `IPE_OFF_CMD);
  assign cmd_op  = I_PWDATA[6:4];
  assign cmd_lvl = I_PWDATA[2:0];
  assign mapped  = (I_PADDR == `IPE_OFF_CTRL) || (I_PADDR == `IPE_OFF_CMD) ||
                   (I_PADDR == `IPE_OFF_PEND) || (I_PADDR == `IPE_OFF_INSVC) ||
                   (I_PADDR == `IPE_OFF_STAT) || (I_PADDR == `IPE_OFF_IMASK) ||
                   (I_PADDR == `IPE_OFF_LOWEST);

  // =====================================================================
  // Acknowledge sequence
  logic final_ack;

  // Counts pulses; the final trailing edge is the second in vector-byte mode, else the third.
  // An unfinished sequence simply waits for its next pulse; there is no timeout here.
  always_ff @(posedge I_CLK) begin
    if (!I_RSTN) begin
      ack_state_r <= ipe_pkg::ACK_IDLE;
    end else if (ack_fall) begin
      unique case (ack_state_r)
        ipe_pkg::ACK_IDLE: begin
          ack_state_r <= ipe_pkg::ACK_FIRST;
        end
        ipe_pkg::ACK_FIRST: begin
          ack_state_r <= ctrl_r[`IPE_CTRL_VBYTE] ? ipe_pkg::ACK_IDLE : ipe_pkg::ACK_SECOND;
        end
        ipe_pkg::ACK_SECOND: begin
          ack_state_r <= ipe_pkg::ACK_IDLE;
        end
      endcase
    end
  end

  assign final_ack = ack_fall && ((ack_state_r == ipe_pkg::ACK_SECOND) ||
                     (ack_state_r == ipe_pkg::ACK_FIRST && ctrl_r[`IPE_CTRL_VBYTE]));

  logic first_ack;
  assign first_ack = ack_rise && (ack_state_r == ipe_pkg::ACK_IDLE);

  // Level chosen on the first pulse is remembered for the whole sequence. [R5]
  always_ff @(posedge I_CLK) begin
    if (!I_RSTN) begin
      sel_level_r <= 3'h0;
    end else if (first_ack && !req_pos[3]) begin
      sel_level_r <= req_level;
    end
  end

  // =====================================================================
  // End-of-service events
  logic       auto_eos;
  logic       ns_eos;
  logic       sp_eos;
  logic       rot_eos;
  logic [7:0] clr_mask;

  // Opcodes outside the command set match none of these, so a stray write clears nothing.
  assign auto_eos = final_ack && ctrl_r[`IPE_CTRL_AUTO];                              // [R11]
  assign ns_eos   = cmd_wr && (cmd_op == `IPE_CMD_NONSPEC || cmd_op == `IPE_CMD_NSROT); // [R18]
  assign sp_eos   = cmd_wr && (cmd_op == `IPE_CMD_SPEC);                              // [R10]
  assign rot_eos  = (cmd_wr && cmd_op == `IPE_CMD_NSROT && !isr_pos[3]) ||
                    (auto_eos && ctrl_r[`IPE_CTRL_AROT] && !isr_pos[3]);

  // Which bits an end-of-service clears this cycle.
  // An automatic and a specific clear in one cycle both take effect.
  always_comb begin
    clr_mask = 8'h00;
    if ((ns_eos || auto_eos) && !isr_pos[3]) begin
      clr_mask[isr_level] = 1'b1;                                                     // [R7]
    end
    if (sp_eos) begin
      clr_mask[cmd_lvl] = 1'b1;                                                       // [R9]
    end
  end

  // In-service bits: acknowledge sets, only an end-of-service clears. [R1] [R2]
  // The automatic clear fires at the final trailing edge, long after the set. [R11]
  // A set and a clear of one bit in the same cycle leave it set, so no acknowledge is lost.
  always_ff @(posedge I_CLK) begin
    if (!I_RSTN) begin
      in_service_bits_r <= 8'h00;
    end else begin
      in_service_bits_r <= (in_service_bits_r & ~clr_mask) |
                           ((first_ack && !req_pos[3]) ? (8'h01 << req_level) : 8'h00);
    end
  end

  // Rotating forms make the cleared level the lowest; reset gives level seven lowest. [R4] [R15] [R16] [R17]
  // With nothing in service a rotating command leaves the pointer where it is.
  always_ff @(posedge I_CLK) begin
    if (!I_RSTN) begin
      lowest_r <= `IPE_LOWEST_RST;
    end else if (rot_eos) begin
      lowest_r <= isr_level;
    end
  end

  // =====================================================================
  // Registers and interrupt output
  // Control and mask registers change only at the access edge of a write.
  // Only the low two mask bits gate the interrupt; the rest are kept for software.
  always_ff @(posedge I_CLK) begin
    if (!I_RSTN) begin
      ctrl_r     <= 3'h0;
      irq_mask_r <= 8'h00;
    end else if (wr_en) begin
      if (I_PADDR == `IPE_OFF_CTRL) begin
        ctrl_r <= I_PWDATA[2:0];
      end
      if (I_PADDR == `IPE_OFF_IMASK) begin
        irq_mask_r <= I_PWDATA[7:0];
      end
    end
  end

  // Events are sticky; a set in the same cycle as a clear wins.
  always_ff @(posedge I_CLK) begin
    if (!I_RSTN) begin
      irq_stat_r <= 2'h0;
    end else begin
      irq_stat_r <= (irq_stat_r & ~((wr_en && I_PADDR == `IPE_OFF_STAT) ? I_PWDATA[1:0] : 2'h0))
                    | {(ns_eos || sp_eos || auto_eos), first_ack};
    end
  end

  // Read data is prepared in setup so the access phase completes at once.
  always_ff @(posedge I_CLK) begin
    if (!I_RSTN) begin
      O_PRDATA  <= 32'h0000_0000;
      O_PREADY  <= 1'b0;
      O_PSLVERR <= 1'b0;
    end else begin
      O_PREADY  <= I_PSEL & ~I_PENABLE;
      // An unmapped address answers with an error and its write is dropped.
      O_PSLVERR <= I_PSEL & ~I_PENABLE & ~mapped;
      if (rd_en) begin
        unique case (I_PADDR)
          `IPE_OFF_CTRL:   O_PRDATA <= {29'h0, ctrl_r};
          `IPE_OFF_PEND:   O_PRDATA <= {24'h0, pending_request_bits};
          `IPE_OFF_INSVC:  O_PRDATA <= {24'h0, in_service_bits_r};
          `IPE_OFF_STAT:   O_PRDATA <= {30'h0, irq_stat_r};
          `IPE_OFF_IMASK:  O_PRDATA <= {24'h0, irq_mask_r};
          `IPE_OFF_LOWEST: O_PRDATA <= {29'h0, lowest_r};
          default:         O_PRDATA <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Registered outputs toward the processor and the system.
  always_ff @(posedge I_CLK) begin
    if (!I_RSTN) begin
      O_INT <= 1'b0;
      O_IRQ <= 1'b0;
    end else begin
      O_INT <= int_nxt;                                                               // [R3]
      O_IRQ <= |(irq_stat_r & irq_mask_r[1:0]);
    end
  end

  // =====================================================================
  // Checks
  // In-service bookkeeping.
  AST_ACK_SETS: assert property (@(posedge I_CLK) disable iff (!I_RSTN) // [R1]
    (first_ack && !req_pos[3] && !auto_eos) |=> in_service_bits_r[$past(req_level)])
    else $error("Acknowledged level not marked in service.");
  AST_PICK: assert property (@(posedge I_CLK) disable iff (!I_RSTN) // [R5]
    (first_ack && !req_pos[3]) |=> (sel_level_r == $past(req_level)))
    else $error("Remembered level is not the highest pending one.");
  AST_HOLD: assert property (@(posedge I_CLK) disable iff (!I_RSTN) // [R2]
    (clr_mask == 8'h00) |=> ((in_service_bits_r & $past(in_service_bits_r)) == $past(in_service_bits_r)))
    else $error("In-service bit dropped without end-of-service.");

  // Priority and interrupt output.
  AST_STRICT: assert property (@(posedge I_CLK) disable iff (!I_RSTN) // [R3]
    (!req_pos[3] && req_pos >= isr_pos) |=> !O_INT)
    else $error("Interrupt raised for non-higher request.");
  AST_FREE_RAISE: assert property (@(posedge I_CLK) disable iff (!I_RSTN) // [R12]
    (!req_pos[3] && isr_pos[3]) |=> O_INT)
    else $error("Request with nothing in service did not interrupt.");
  AST_RESET_ORDER: assert property (@(posedge I_CLK) // [R4]
    !I_RSTN |=> (lowest_r == `IPE_LOWEST_RST && in_service_bits_r == 8'h00))
    else $error("Reset priority order wrong.");

  // End-of-service forms and rotation.
  AST_NONSPEC: assert property (@(posedge I_CLK) disable iff (!I_RSTN) // [R7]
    (ns_eos && !isr_pos[3] && !first_ack) |=> !in_service_bits_r[$past(isr_level)])
    else $error("Non-specific end-of-service missed highest bit.");
  AST_SPEC: assert property (@(posedge I_CLK) disable iff (!I_RSTN) // [R9]
    (sp_eos && !first_ack) |=> !in_service_bits_r[$past(cmd_lvl)])
    else $error("Specific end-of-service missed named bit.");
  AST_SPEC_ONLY: assert property (@(posedge I_CLK) disable iff (!I_RSTN) // [R9]
    (sp_eos && !first_ack && !auto_eos) |=>
      (in_service_bits_r == ($past(in_service_bits_r) & ~(8'h01 << $past(cmd_lvl)))))
    else $error("Specific end-of-service touched another bit.");
  AST_AUTO: assert property (@(posedge I_CLK) disable iff (!I_RSTN) // [R11]
    (final_ack && ctrl_r[`IPE_CTRL_AUTO] && !isr_pos[3] && !first_ack) |=> !in_service_bits_r[$past(isr_level)])
    else $error("Automatic end-of-service did not clear.");
  AST_ROTATE: assert property (@(posedge I_CLK) disable iff (!I_RSTN) // [R15]
    (cmd_wr && cmd_op == `IPE_CMD_NSROT && !isr_pos[3]) |=> (lowest_r == $past(isr_level)))
    else $error("Rotation did not make cleared level lowest.");
  AST_AUTO_ROT: assert property (@(posedge I_CLK) disable iff (!I_RSTN) // [R16]
    (auto_eos && ctrl_r[`IPE_CTRL_AROT] && !isr_pos[3]) |=> (lowest_r == $past(isr_level)))
    else $error("Automatic rotation did not make serviced level lowest.");

  // Acknowledge sequence.
  AST_SEQ_END: assert property (@(posedge I_CLK) disable iff (!I_RSTN) // [R11]
    final_ack |=> (ack_state_r == ipe_pkg::ACK_IDLE))
    else $error("Acknowledge sequence did not end at the final pulse.");

endmodule

// *** verilog/ipe_map.svh ***
// Constants for the interrupt priority and end-of-service block.
`ifndef IPE_MAP_SVH
`define IPE_MAP_SVH
// =====================================================================
// Register offsets
`define IPE_OFF_CTRL     12'h000
`define IPE_OFF_CMD      12'h004
`define IPE_OFF_PEND     12'h008
`define IPE_OFF_INSVC    12'h00c
`define IPE_OFF_STAT     12'h010
`define IPE_OFF_IMASK    12'h014
`define IPE_OFF_LOWEST   12'h018
// =====================================================================
// Control register fields
`define IPE_CTRL_AUTO    0
`define IPE_CTRL_AROT    1
`define IPE_CTRL_VBYTE   2
// Command word encodings, opcode in bits 6:4, level in bits 2:0.
`define IPE_CMD_NONSPEC  3'h1
`define IPE_CMD_SPEC     3'h3
`define IPE_CMD_NSROT    3'h5
// Status bits
`define IPE_ST_ACK       0
`define IPE_ST_EOS       1
// Reset values
`define IPE_LOWEST_RST   3'h7
`endif

// *** verilog/ipe_pkg.sv ***
// Types for the interrupt priority and end-of-service block.
package ipe_pkg;
  typedef enum logic [1:0] {ACK_IDLE, ACK_FIRST, ACK_SECOND} ipe_ack_type;
endpackage
